// ==== rtl/mbr_dev.sv ====
// Axis responder serving the position-number status register read
//
// The plain strobed port was chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module mbr_dev #(
	parameter int SILENT_CYCLES = mbr_pkg::SILENT_CYC,
	parameter int GAP_CYCLES    = mbr_pkg::GAP_CYC
) (
	// Clock and reset
	input  wire logic       sys_clk_in,
	input  wire logic       rst_b_in,
	// Link
	mbr_link_if.dev         link,
	// Axis identity
	input  wire logic [3:0] axis_no_in,
	// Position or program number bits
	input  wire logic       posnum_bit_w1_in,
	input  wire logic       posnum_bit_w2_in,
	input  wire logic       posnum_bit_w4_in,
	input  wire logic       posnum_bit_w8_in,
	input  wire logic       posnum_bit_w16_in,
	input  wire logic       posnum_bit_w32_in,
	input  wire logic       posnum_bit_w64_in,
	input  wire logic       posnum_bit_w128_in,
	input  wire logic       posnum_bit_w256_in,
	input  wire logic       posnum_bit_w512_in,
	// Event reports
	output logic            query_ok_out,
	output logic            crc_err_out,
	output logic            reply_busy_out
);
	import mbr_pkg::*;

	typedef enum logic [1:0] {
		ST_RX = 2'b01,
		ST_TX = 2'b10
	} mbr_dev_st_t;

	// Refuse counts the counters cannot hold
	if (SILENT_CYCLES < 2 || SILENT_CYCLES >= (1 << CNT_W)) begin : g_bad_silent
		$error("SILENT_CYCLES out of range");
	end
	if (GAP_CYCLES < 1 || GAP_CYCLES >= (1 << CNT_W)) begin : g_bad_gap
		$error("GAP_CYCLES out of range");
	end

	localparam logic [CNT_W-1:0] SIL_LAST = CNT_W'(SILENT_CYCLES - 1);
	localparam logic [CNT_W-1:0] SIL_FULL = CNT_W'(SILENT_CYCLES);
	localparam logic [CNT_W-1:0] GAP_LAST = CNT_W'(GAP_CYCLES - 1);
	localparam logic [3:0] QRY_N = 4'(QRY_LEN);
	localparam logic [3:0] RSP_LAST = 4'(RSP_LEN - 1);

	mbr_dev_st_t      st_r;
	mbr_dev_st_t      st_nxt;
	logic [CNT_W-1:0] idle_cnt_r;
	logic [3:0]       rx_idx_r;
	mbr_byte_t        rx_buf_r [QRY_LEN];
	logic [15:0]      rx_crc_r;
	logic [15:0]      word_r;
	logic [7:0]       addr_r;
	logic [3:0]       tx_idx_r;
	logic [CNT_W-1:0] gap_cnt_r;
	logic [15:0]      tx_crc_r;
	logic             r_vld_r;
	mbr_byte_t        r_byte_r;
	logic             query_ok_r;
	logic             crc_err_r;
	logic             busy_r;

	// Status word assembled from the number inputs
	wire [POSNUM_W-1:0] posnum_w = {
		posnum_bit_w512_in, posnum_bit_w256_in, posnum_bit_w128_in,
		posnum_bit_w64_in, posnum_bit_w32_in, posnum_bit_w16_in,
		posnum_bit_w8_in, posnum_bit_w4_in, posnum_bit_w2_in,
		posnum_bit_w1_in
	};
	wire [15:0] status_word;
	genvar g;
	generate
		for (g = 0; g < POSNUM_W; g++) begin : g_num
			assign status_word[POSNUM_LSB + g] = posnum_w[g];
		end
	endgenerate
	assign status_word[WORD_W-1:POSNUM_W] = '0;

	// own address is axis plus one
	wire [7:0] own_addr = 8'({4'h0, axis_no_in}) + ADDR_MIN;

	// frame closes after a full silent interval
	wire frame_end = !link.q_vld && (idle_cnt_r == SIL_LAST);
	wire frame_any = frame_end && (rx_idx_r != 4'h0);
	// query must be exactly eight bytes
	wire len_ok = (rx_idx_r == QRY_N);
	// CRC over whole frame leaves zero
	wire crc_ok = (rx_crc_r == 16'h0000);
	wire [15:0] start_w = {rx_buf_r[2], rx_buf_r[3]};
	wire [15:0] count_w = {rx_buf_r[4], rx_buf_r[5]};
	wire addr_hit = (rx_buf_r[0] == own_addr);
	// function and count as the master sends them
	wire func_hit = (rx_buf_r[1] == FUNC_RD);
	wire count_hit = (count_w == REG_COUNT);
	wire reg_hit = (start_w == REG_POSNUM);
	wire accept = frame_any && len_ok && crc_ok && addr_hit && func_hit
		&& reg_hit && count_hit && (st_r == ST_RX);
	wire crc_bad = frame_any && len_ok && !crc_ok;

	// Reply byte selection
	// address, function, count, data, CRC order
	// CRC low byte first on the wire
	logic [7:0] tx_sel;
	always_comb begin
		unique case (tx_idx_r)
			4'h0:    tx_sel = addr_r;
			4'h1:    tx_sel = FUNC_RD;
			4'h2:    tx_sel = BYTE_CNT;
			4'h3:    tx_sel = word_r[15:8];
			4'h4:    tx_sel = word_r[7:0];
			4'h5:    tx_sel = tx_crc_r[7:0];
			default: tx_sel = tx_crc_r[15:8];
		endcase
	end

	wire tx_fire = (st_r == ST_TX) && (gap_cnt_r == GAP_LAST);
	wire tx_last = tx_fire && (tx_idx_r == RSP_LAST);

	always_comb begin
		st_nxt = st_r;
		unique case (st_r)
			ST_RX: if (accept) st_nxt = ST_TX;
			ST_TX: if (tx_last) st_nxt = ST_RX;
			default: st_nxt = ST_RX;
		endcase
	end

	always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
		if (!rst_b_in)
			st_r <= ST_RX;
		else
			st_r <= st_nxt;
	end

	always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
		if (!rst_b_in)
			idle_cnt_r <= '0;
		else if (link.q_vld)
			idle_cnt_r <= '0;
		else if (idle_cnt_r != SIL_FULL)
			idle_cnt_r <= idle_cnt_r + 1'b1;
	end

	// Query capture; extra bytes saturate the index so the frame fails
	always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			rx_idx_r <= '0;
			rx_crc_r <= CRC_INIT;
		end else if (frame_end) begin
			rx_idx_r <= '0;
			rx_crc_r <= CRC_INIT;
		end else if (link.q_vld) begin
			rx_crc_r <= mbr_crc_step(rx_crc_r, link.q_byte);
			if (rx_idx_r <= QRY_N)
				rx_idx_r <= rx_idx_r + 1'b1;
		end
	end

	generate
		for (g = 0; g < QRY_LEN; g++) begin : g_buf
			always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
				if (!rst_b_in)
					rx_buf_r[g] <= '0;
				else if (link.q_vld && rx_idx_r == 4'(g))
					rx_buf_r[g] <= link.q_byte;
			end
		end
	endgenerate

	// Snapshot of reply contents at acceptance
	always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			word_r <= '0;
			addr_r <= '0;
		end else if (accept) begin
			word_r <= status_word;
			addr_r <= rx_buf_r[0];
		end
	end

	// Reply pacing and running CRC
	always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			tx_idx_r  <= '0;
			gap_cnt_r <= '0;
			tx_crc_r  <= CRC_INIT;
		end else if (st_r != ST_TX) begin
			tx_idx_r  <= '0;
			gap_cnt_r <= '0;
			tx_crc_r  <= CRC_INIT;
		end else if (tx_fire) begin
			gap_cnt_r <= '0;
			tx_idx_r  <= tx_idx_r + 1'b1;
			if (tx_idx_r < 4'h5)
				tx_crc_r <= mbr_crc_step(tx_crc_r, tx_sel);
		end else begin
			gap_cnt_r <= gap_cnt_r + 1'b1;
		end
	end

	always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			r_vld_r  <= 1'b0;
			r_byte_r <= '0;
		end else begin
			r_vld_r  <= tx_fire;
			r_byte_r <= tx_fire ? tx_sel : r_byte_r;
		end
	end

	always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			query_ok_r <= 1'b0;
			crc_err_r  <= 1'b0;
			busy_r     <= 1'b0;
		end else begin
			query_ok_r <= accept;
			crc_err_r  <= crc_bad;
			busy_r     <= (st_nxt == ST_TX) || tx_fire;
		end
	end

	assign link.r_vld   = r_vld_r;
	assign link.r_byte  = r_byte_r;
	assign query_ok_out = query_ok_r;
	assign crc_err_out  = crc_err_r;
	assign reply_busy_out = busy_r;
endmodule // mbr_dev
`default_nettype wire

// ==== rtl/mbr_host.sv ====
// Host master issuing the position-number status read
`timescale 1ns/1ps
`default_nettype none
module mbr_host #(
	parameter int SILENT_CYCLES = mbr_pkg::SILENT_CYC,
	parameter int GAP_CYCLES    = mbr_pkg::GAP_CYC,
	parameter int TMO_CYCLES    = mbr_pkg::TMO_CYC
) (
	// Clock and reset
	input  wire logic        sys_clk_in,
	input  wire logic        rst_b_in,
	// Register port
	input  wire logic [3:0]  reg_addr_in,
	input  wire logic [15:0] reg_wdata_in,
	input  wire logic        reg_wr_in,
	input  wire logic        reg_rd_in,
	output logic      [15:0] reg_rdata_out,
	// Link
	mbr_link_if.host         link
);
	import mbr_pkg::*;

	typedef enum logic [3:0] {
		HS_IDLE = 4'b0001,
		HS_WAIT = 4'b0010,
		HS_SEND = 4'b0100,
		HS_RECV = 4'b1000
	} mbr_host_st_t;

	// Refuse counts the counters cannot hold
	if (SILENT_CYCLES < 2 || SILENT_CYCLES >= (1 << CNT_W)) begin : g_bad_silent
		$error("SILENT_CYCLES out of range");
	end
	if (GAP_CYCLES < 1 || TMO_CYCLES <= SILENT_CYCLES || TMO_CYCLES >= (1 << CNT_W))
	begin : g_bad_timing
		$error("GAP_CYCLES or TMO_CYCLES out of range");
	end

	localparam logic [CNT_W-1:0] SIL_FULL = CNT_W'(SILENT_CYCLES);
	localparam logic [CNT_W-1:0] GAP_LAST = CNT_W'(GAP_CYCLES - 1);
	localparam logic [CNT_W-1:0] TMO_LAST = CNT_W'(TMO_CYCLES - 1);
	localparam logic [3:0] QRY_LAST = 4'(QRY_LEN - 1);
	localparam logic [3:0] RSP_N = 4'(RSP_LEN);

	mbr_host_st_t     st_r;
	logic [CNT_W-1:0] idle_cnt_r;
	logic [CNT_W-1:0] gap_cnt_r;
	logic [CNT_W-1:0] tmo_cnt_r;
	logic [3:0]       axis_r;
	logic [3:0]       idx_r;
	logic [15:0]      crc_r;
	mbr_byte_t        rsp_r [RSP_LEN];
	logic [15:0]      data_r;
	logic             done_r;
	logic             crcerr_r;
	logic             tmo_r;
	logic             badrsp_r;
	logic             q_vld_r;
	mbr_byte_t        q_byte_r;
	logic [15:0]      rdata_r;

	wire wr_ctrl = reg_wr_in && (reg_addr_in == OFS_CTRL);
	wire wr_stat = reg_wr_in && (reg_addr_in == OFS_STAT);
	wire go = wr_ctrl && reg_wdata_in[CTRL_GO] && (st_r == HS_IDLE);
	wire line_quiet = (idle_cnt_r == SIL_FULL);
	wire [7:0] slave_addr = 8'({4'h0, axis_r}) + ADDR_MIN;

	// Query bytes: address, function, start, count, CRC low then high
	// fixed function, start, count
	logic [7:0] q_sel;
	always_comb begin
		unique case (idx_r)
			4'h0:    q_sel = slave_addr;
			4'h1:    q_sel = FUNC_RD;
			4'h2:    q_sel = REG_POSNUM[15:8];
			4'h3:    q_sel = REG_POSNUM[7:0];
			4'h4:    q_sel = REG_COUNT[15:8];
			4'h5:    q_sel = REG_COUNT[7:0];
			4'h6:    q_sel = crc_r[7:0];
			default: q_sel = crc_r[15:8];
		endcase
	end

	wire q_fire = (st_r == HS_SEND) && (gap_cnt_r == GAP_LAST);
	wire rsp_close = (st_r == HS_RECV) && (idx_r != 4'h0) && line_quiet;
	wire rsp_tmo = (st_r == HS_RECV) && (tmo_cnt_r == TMO_LAST);
	wire rsp_fmt = (idx_r == RSP_N) && (rsp_r[0] == slave_addr)
		&& (rsp_r[1] == FUNC_RD) && (rsp_r[2] == BYTE_CNT);
	wire rsp_good = rsp_close && rsp_fmt && (crc_r == 16'h0000);
	wire rsp_crc_bad = rsp_close && (idx_r == RSP_N) && (crc_r != 16'h0000);
	wire rsp_bad = rsp_close && !rsp_good && !rsp_crc_bad;

	always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
		if (!rst_b_in)
			idle_cnt_r <= '0;
		else if (link.q_vld || link.r_vld)
			idle_cnt_r <= '0;
		else if (!line_quiet)
			idle_cnt_r <= idle_cnt_r + 1'b1;
	end

	always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			st_r      <= HS_IDLE;
			axis_r    <= '0;
			idx_r     <= '0;
			gap_cnt_r <= '0;
			tmo_cnt_r <= '0;
			crc_r     <= CRC_INIT;
		end else begin
			unique case (st_r)
				HS_IDLE: if (go) begin
					axis_r <= reg_wdata_in[CTRL_AXIS_LSB +: 4];
					st_r   <= HS_WAIT;
				end
				HS_WAIT: if (line_quiet) begin
					st_r      <= HS_SEND;
					idx_r     <= '0;
					gap_cnt_r <= '0;
					crc_r     <= CRC_INIT;
				end
				HS_SEND: if (q_fire) begin
					gap_cnt_r <= '0;
					idx_r     <= idx_r + 1'b1;
					if (idx_r < 4'h6)
						crc_r <= mbr_crc_step(crc_r, q_sel);
					if (idx_r == QRY_LAST) begin
						st_r      <= HS_RECV;
						idx_r     <= '0;
						tmo_cnt_r <= '0;
						crc_r     <= CRC_INIT;
					end
				end else begin
					gap_cnt_r <= gap_cnt_r + 1'b1;
				end
				HS_RECV: begin
					tmo_cnt_r <= tmo_cnt_r + 1'b1;
					if (rsp_close || rsp_tmo)
						st_r <= HS_IDLE;
					else if (link.r_vld) begin
						crc_r <= mbr_crc_step(crc_r, link.r_byte);
						if (idx_r <= RSP_N)
							idx_r <= idx_r + 1'b1;
					end
				end
				default: st_r <= HS_IDLE;
			endcase
		end
	end

	genvar g;
	generate
		for (g = 0; g < RSP_LEN; g++) begin : g_rsp
			always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
				if (!rst_b_in)
					rsp_r[g] <= '0;
				else if (st_r == HS_RECV && link.r_vld && idx_r == 4'(g))
					rsp_r[g] <= link.r_byte;
			end
		end
	endgenerate

	// Sticky flags: write one to clear, a new event wins
	always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			done_r   <= 1'b0;
			crcerr_r <= 1'b0;
			tmo_r    <= 1'b0;
			badrsp_r <= 1'b0;
			data_r   <= '0;
		end else begin
			done_r   <= rsp_good || (done_r && !(wr_stat && reg_wdata_in[STAT_DONE]));
			crcerr_r <= rsp_crc_bad || (crcerr_r && !(wr_stat && reg_wdata_in[STAT_CRCERR]));
			tmo_r    <= rsp_tmo || (tmo_r && !(wr_stat && reg_wdata_in[STAT_TMO]));
			badrsp_r <= rsp_bad || (badrsp_r && !(wr_stat && reg_wdata_in[STAT_BADRSP]));
			if (rsp_good)
				data_r <= {rsp_r[3], rsp_r[4]};
		end
	end

	logic [15:0] stat_w;
	always_comb begin
		stat_w = '0;
		stat_w[STAT_DONE]   = done_r;
		stat_w[STAT_CRCERR] = crcerr_r;
		stat_w[STAT_TMO]    = tmo_r;
		stat_w[STAT_BUSY]   = (st_r != HS_IDLE);
		stat_w[STAT_BADRSP] = badrsp_r;
	end

	wire [15:0] rd_mux = (reg_addr_in == OFS_STAT) ? stat_w :
		(reg_addr_in == OFS_DATA) ? data_r :
		(reg_addr_in == OFS_CTRL) ? {8'h00, axis_r, 4'h0} : 16'h0000;

	always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			rdata_r  <= '0;
			q_vld_r  <= 1'b0;
			q_byte_r <= '0;
		end else begin
			rdata_r  <= reg_rd_in ? rd_mux : 16'h0000;
			q_vld_r  <= q_fire;
			q_byte_r <= q_fire ? q_sel : q_byte_r;
		end
	end

	assign reg_rdata_out = rdata_r;
	assign link.q_vld    = q_vld_r;
	assign link.q_byte   = q_byte_r;
endmodule // mbr_host
`default_nettype wire

// ==== rtl/mbr_link_if.sv ====
// Byte-level serial link between host master and axis responder
`timescale 1ns/1ps
`default_nettype none
interface mbr_link_if;
	// Query bytes, host to device
	logic       q_vld;
	logic [7:0] q_byte;
	// Response bytes, device to host
	logic       r_vld;
	logic [7:0] r_byte;

	modport dev (
		input  q_vld,
		input  q_byte,
		output r_vld,
		output r_byte
	);
	modport host (
		output q_vld,
		output q_byte,
		input  r_vld,
		input  r_byte
	);
endinterface
`default_nettype wire

// ==== rtl/mbr_pkg.sv ====
// Shared constants, types and CRC step for the position-number read link
package mbr_pkg;
	// Frame layout
	localparam int QRY_LEN = 8;
	localparam int RSP_LEN = 7;
	localparam logic [7:0] FUNC_RD = 8'h03;
	localparam logic [15:0] REG_POSNUM = 16'h9014;
	localparam logic [15:0] REG_COUNT = 16'h0001;
	localparam logic [7:0] BYTE_CNT = 8'h02;
	localparam logic [7:0] ADDR_MIN = 8'h01;
	localparam logic [7:0] ADDR_MAX = 8'h10;
	// Status word layout
	localparam int POSNUM_LSB = 0;
	localparam int POSNUM_W = 10;
	localparam int WORD_W = 16;
	// CRC
	localparam logic [15:0] CRC_INIT = 16'hFFFF;
	localparam logic [15:0] CRC_POLY = 16'hA001;
	// Timing at 40 MHz
	localparam int CLK_NS = 25;
	localparam int SILENT_NS = 1750000;
	localparam int SILENT_CYC = (SILENT_NS + CLK_NS - 1) / CLK_NS;
	localparam int GAP_NS = 100;
	localparam int GAP_CYC = (GAP_NS + CLK_NS - 1) / CLK_NS;
	localparam int TMO_NS = 100000000;
	localparam int TMO_CYC = TMO_NS / CLK_NS;
	localparam int CNT_W = 24;
	// Host register map
	localparam logic [3:0] OFS_CTRL = 4'h0;
	localparam logic [3:0] OFS_STAT = 4'h1;
	localparam logic [3:0] OFS_DATA = 4'h2;
	localparam int CTRL_GO = 0;
	localparam int CTRL_AXIS_LSB = 4;
	localparam int STAT_DONE = 0;
	localparam int STAT_CRCERR = 1;
	localparam int STAT_TMO = 2;
	localparam int STAT_BUSY = 3;
	localparam int STAT_BADRSP = 4;

	typedef logic [7:0] mbr_byte_t;

	function automatic logic [15:0] mbr_crc_step(input logic [15:0] c, input logic [7:0] b);
		logic [15:0] x;
		x = c ^ {8'h00, b};
		for (int i = 0; i < 8; i++) begin
			x = x[0] ? ((x >> 1) ^ CRC_POLY) : (x >> 1);
		end
		return x;
	endfunction
endpackage

// ==== verif/mbr_link_checker.sv ====
// Concurrent checks on the link between host and responder
`timescale 1ns/1ps
`default_nettype none
module mbr_link_checker #(
	parameter int SILENT_CYCLES = 20
) (
	// Clock and reset
	input  wire logic       sys_clk_in,
	input  wire logic       rst_b_in,
	// Link signals
	input  wire logic       q_vld,
	input  wire logic [7:0] q_byte,
	input  wire logic       r_vld,
	input  wire logic [7:0] r_byte
);
	import mbr_pkg::*;
	logic [15:0] idle_r;
	logic [3:0]  q_idx_r;
	logic [3:0]  r_idx_r;
	wire  logic        any_vld;
	wire  logic        frame_gap;
	wire  logic [15:0] idle_nxt;
	wire  logic [3:0]  q_idx_nxt;
	wire  logic [3:0]  r_idx_nxt;
	// Quiet-cycle count and byte position within each frame
	assign any_vld   = q_vld | r_vld;
	assign frame_gap = idle_r > 16'h0008;
	assign idle_nxt  = any_vld ? 16'h0000 : ((&idle_r) ? idle_r : idle_r + 16'h0001);
	assign q_idx_nxt = q_vld ? q_idx_r + 4'h1 : (frame_gap ? 4'h0 : q_idx_r);
	assign r_idx_nxt = r_vld ? r_idx_r + 4'h1 : (frame_gap ? 4'h0 : r_idx_r);
	always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			idle_r  <= 16'h0000;
			q_idx_r <= 4'h0;
			r_idx_r <= 4'h0;
		end else begin
			idle_r  <= idle_nxt;
			q_idx_r <= q_idx_nxt;
			r_idx_r <= r_idx_nxt;
		end
	end
	default clocking @(posedge sys_clk_in); endclocking
	default disable iff (!rst_b_in);
	sequence rsp_head_s;
		(r_vld && r_byte == FUNC_RD) ##4 (r_vld && r_byte == BYTE_CNT);
	endsequence
	sequence rsp_gap_s;
		!r_vld [*3];
	endsequence
	addr_range_a: assert property (
		r_vld && r_idx_r == 4'h0 |-> r_byte >= ADDR_MIN && r_byte <= ADDR_MAX)
		else $error("reply address out of range");
	rsp_head_a: assert property (r_vld && r_idx_r == 4'h0 |-> ##4 rsp_head_s)
		else $error("reply header wrong");
	high_zero_a: assert property (r_vld && r_idx_r == 4'h3 |-> r_byte[7:2] == 6'h00)
		else $error("unused status bits not zero");
	rsp_len_a: assert property (idle_r == 16'h0009 && r_idx_r != 4'h0 |-> r_idx_r == 4'h7)
		else $error("reply length not 7");
	qry_len_a: assert property (idle_r == 16'h0009 && q_idx_r != 4'h0 |-> q_idx_r == 4'h8)
		else $error("query length not 8");
	rsp_silent_a: assert property (r_vld && r_idx_r == 4'h0 |-> idle_r >= SILENT_CYCLES)
		else $error("reply started without silence");
	qry_silent_a: assert property (q_vld && q_idx_r == 4'h0 |-> idle_r >= SILENT_CYCLES - 1)
		else $error("query started without silence");
	rsp_spacing_a: assert property (r_vld |=> rsp_gap_s)
		else $error("reply bytes too close");
	no_overlap_a: assert property (q_vld |-> !r_vld && r_idx_r == 4'h0)
		else $error("query byte inside a reply");
endmodule // mbr_link_checker
`default_nettype wire

// ==== verif/modbus_position_number_status_read_tb_top.sv ====
// Bench for host and responder joined over the link, plus a stand-alone responder
`timescale 1ns/1ps
`default_nettype none
module modbus_position_number_status_read_tb_top;
	import mbr_pkg::*;
	typedef logic [7:0] mbr_bq_t[$];
	typedef struct {logic [3:0] ax; logic [9:0] pn; logic [15:0] word;} mbr_row_t;
	localparam int SIL = 20;
	localparam int GAP = 4;
	logic        sys_clk_in;
	logic        rst_b_in  = 1'b0;
	logic [3:0]  reg_addr  = 4'h0;
	logic [15:0] reg_wdata = 16'h0000;
	logic        reg_wr    = 1'b0;
	logic        reg_rd    = 1'b0;
	logic [15:0] reg_rdata;
	logic [3:0]  axis_no   = 4'h0;
	logic [9:0]  pn        = 10'h000;
	logic        ok_a, err_a, busy_a, ok_b, err_b, busy_b;
	logic [15:0] v;
	int          failures = 0;
	int          comparisons = 0;
	int          cyc = 0;
	int          oka_n = 0;
	int          ok_n = 0;
	int          err_n = 0;
	int          rb_n = 0;
	int          bz_n = 0;
	int          a0;
	mbr_bq_t     qq, rq, e;
	mbr_row_t    rows [4] = '{'{4'h0, 10'h003, 16'h0003}, '{4'hF, 10'h3FF, 16'h03FF},
		'{4'h5, 10'h200, 16'h0200}, '{4'h9, 10'h155, 16'h0155}};
	mbr_link_if link_a ();
	mbr_link_if link_b ();
	mbr_host #(.SILENT_CYCLES(SIL), .GAP_CYCLES(GAP), .TMO_CYCLES(200)) mbr_host_inst (
		.sys_clk_in(sys_clk_in), .rst_b_in(rst_b_in), .reg_addr_in(reg_addr),
		.reg_wdata_in(reg_wdata), .reg_wr_in(reg_wr), .reg_rd_in(reg_rd),
		.reg_rdata_out(reg_rdata), .link(link_a.host));
	mbr_dev #(.SILENT_CYCLES(SIL), .GAP_CYCLES(GAP)) mbr_dev_inst (
		.sys_clk_in(sys_clk_in), .rst_b_in(rst_b_in), .link(link_a.dev), .axis_no_in(axis_no),
		.posnum_bit_w1_in(pn[0]), .posnum_bit_w2_in(pn[1]), .posnum_bit_w4_in(pn[2]),
		.posnum_bit_w8_in(pn[3]), .posnum_bit_w16_in(pn[4]), .posnum_bit_w32_in(pn[5]),
		.posnum_bit_w64_in(pn[6]), .posnum_bit_w128_in(pn[7]), .posnum_bit_w256_in(pn[8]),
		.posnum_bit_w512_in(pn[9]), .query_ok_out(ok_a), .crc_err_out(err_a),
		.reply_busy_out(busy_a));
	// Second responder faces the bench driver on its own link
	mbr_dev #(.SILENT_CYCLES(SIL), .GAP_CYCLES(GAP)) mbr_dev_inst2 (
		.sys_clk_in(sys_clk_in), .rst_b_in(rst_b_in), .link(link_b.dev), .axis_no_in(4'h0),
		.posnum_bit_w1_in(pn[0]), .posnum_bit_w2_in(pn[1]), .posnum_bit_w4_in(pn[2]),
		.posnum_bit_w8_in(pn[3]), .posnum_bit_w16_in(pn[4]), .posnum_bit_w32_in(pn[5]),
		.posnum_bit_w64_in(pn[6]), .posnum_bit_w128_in(pn[7]), .posnum_bit_w256_in(pn[8]),
		.posnum_bit_w512_in(pn[9]), .query_ok_out(ok_b), .crc_err_out(err_b),
		.reply_busy_out(busy_b));
	mbr_link_checker #(.SILENT_CYCLES(SIL)) mbr_link_checker_inst (
		.sys_clk_in(sys_clk_in), .rst_b_in(rst_b_in), .q_vld(link_a.q_vld),
		.q_byte(link_a.q_byte), .r_vld(link_a.r_vld), .r_byte(link_a.r_byte));
	initial begin
		sys_clk_in = 1'b0;
		forever #12.5 sys_clk_in = ~sys_clk_in;
	end
	always @(posedge sys_clk_in) begin
		cyc++;
		oka_n += ok_a;
		ok_n += ok_b;
		err_n += err_b;
		rb_n += link_b.r_vld;
		bz_n += busy_b;
		if (link_a.q_vld === 1'b1) qq.push_back(link_a.q_byte);
		if (link_a.r_vld === 1'b1) rq.push_back(link_a.r_byte);
		if (cyc == 10000) begin
			failures++;
			tally_and_finish();
		end
	end
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		comparisons++;
		if (got !== exp) begin
			failures++;
			$display("[FAIL] %0t got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic chk_frame(input mbr_bq_t got, input mbr_bq_t exp);
		chk(16'(got.size()), 16'(exp.size()));
		foreach (exp[i]) chk({8'h00, got[i]}, {8'h00, exp[i]});
	endtask
	// Appends the check field, low byte first
	function automatic mbr_bq_t sealed(input mbr_bq_t b);
		logic [15:0] c;
		c = 16'hFFFF;
		foreach (b[i]) begin
			c = c ^ {8'h00, b[i]};
			repeat (8) c = c[0] ? ((c >> 1) ^ 16'hA001) : (c >> 1);
		end
		b.push_back(c[7:0]);
		b.push_back(c[15:8]);
		return b;
	endfunction
	task automatic wr(input logic [3:0] a, input logic [15:0] d);
		@(posedge sys_clk_in);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge sys_clk_in);
		reg_wr <= 1'b0;
	endtask
	task automatic rd(input logic [3:0] a, output logic [15:0] d);
		@(posedge sys_clk_in);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge sys_clk_in);
		reg_rd <= 1'b0;
		#1 d = reg_rdata;
	endtask
	task automatic wait_flag(output logic [15:0] d);
		for (int k = 0; k < 300; k++) begin
			rd(OFS_STAT, d);
			if (d[STAT_DONE] === 1'b1 || d[STAT_TMO] === 1'b1) break;
		end
	endtask
	task automatic send_b(input mbr_bq_t f, input int x_ok, input int x_err, input int x_r);
		int o0, e0, r0, b0;
		o0 = ok_n;
		e0 = err_n;
		r0 = rb_n;
		b0 = bz_n;
		foreach (f[i]) begin
			@(posedge sys_clk_in);
			link_b.q_vld <= 1'b1;
			link_b.q_byte <= f[i];
			@(posedge sys_clk_in);
			link_b.q_vld <= 1'b0;
			repeat (2) @(posedge sys_clk_in);
		end
		link_b.q_byte <= ~link_b.q_byte;
		repeat (SIL + 60) @(posedge sys_clk_in);
		chk(16'(ok_n - o0), 16'(x_ok));
		chk(16'(err_n - e0), 16'(x_err));
		chk(16'(rb_n - r0), 16'(x_r));
		chk(16'(bz_n - b0), (x_r != 0) ? 16'(GAP * RSP_LEN + 1) : 16'h0000);
	endtask
	task tally_and_finish;
		$display("comparisons %0d failures %0d", comparisons, failures);
		if (failures == 0 && comparisons > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	initial begin
		link_b.q_vld = 1'b0;
		link_b.q_byte = 8'h00;
		repeat (10) @(posedge sys_clk_in);
		rst_b_in <= 1'b1;
		repeat (SIL + 5) @(posedge sys_clk_in);
		wr(4'hF, 16'hFFFF);
		rd(4'hF, v);
		chk(v, 16'h0000);
		foreach (rows[i]) begin
			@(posedge sys_clk_in);
			axis_no <= rows[i].ax;
			pn <= rows[i].pn;
			qq.delete();
			rq.delete();
			a0 = oka_n;
			wr(OFS_CTRL, {8'h00, rows[i].ax, 4'h1});
			wait_flag(v);
			chk(v, 16'h0001);
			rd(OFS_CTRL, v);
			chk(v, {8'h00, rows[i].ax, 4'h0});
			rd(OFS_DATA, v);
			chk(v, rows[i].word);
			e = sealed('{{4'h0, rows[i].ax} + 8'h01, 8'h03, 8'h90, 8'h14, 8'h00, 8'h01});
			chk_frame(qq, e);
			e = sealed('{{4'h0, rows[i].ax} + 8'h01, 8'h03, 8'h02, rows[i].word[15:8],
				rows[i].word[7:0]});
			chk_frame(rq, e);
			chk(16'(oka_n - a0), 16'h0001);
			wr(OFS_STAT, 16'h0017);
			rd(OFS_STAT, v);
			chk(v, 16'h0000);
		end
		// Responder on another axis stays quiet, host times out
		rq.delete();
		@(posedge sys_clk_in);
		axis_no <= 4'h4;
		wr(OFS_CTRL, 16'h0031);
		wait_flag(v);
		chk(v, 16'h0004);
		chk(16'(rq.size()), 16'h0000);
		wr(OFS_STAT, 16'h0017);
		pn <= 10'h2A5;
		e = sealed('{8'h01, 8'h03, 8'h90, 8'h14, 8'h00, 8'h01});
		send_b(e, 1, 0, 7);
		e[7] = e[7] ^ 8'h01;
		send_b(e, 0, 1, 0);
		e.pop_back();
		send_b(e, 0, 0, 0);
		send_b(sealed('{8'h02, 8'h03, 8'h90, 8'h14, 8'h00, 8'h01}), 0, 0, 0);
		send_b(sealed('{8'h01, 8'h04, 8'h90, 8'h14, 8'h00, 8'h01}), 0, 0, 0);
		send_b(sealed('{8'h01, 8'h03, 8'h90, 8'h13, 8'h00, 8'h01}), 0, 0, 0);
		send_b(sealed('{8'h01, 8'h03, 8'h90, 8'h14, 8'h00, 8'h02}), 0, 0, 0);
		// Reset in the middle of a query
		axis_no <= 4'h2;
		wr(OFS_CTRL, 16'h0021);
		repeat (12) @(posedge sys_clk_in);
		rst_b_in <= 1'b0;
		#1 chk({12'h000, ok_a, busy_a, link_a.q_vld, link_a.r_vld}, 16'h0000);
		repeat (10) @(posedge sys_clk_in);
		rst_b_in <= 1'b1;
		repeat (SIL + 5) @(posedge sys_clk_in);
		rd(OFS_STAT, v);
		chk(v, 16'h0000);
		// A fresh read after the cut frame completes normally
		wr(OFS_CTRL, 16'h0021);
		wait_flag(v);
		chk(v, 16'h0001);
		rd(OFS_DATA, v);
		chk(v, 16'h02A5);
		tally_and_finish();
	end
endmodule // modbus_position_number_status_read_tb_top
`default_nettype wire
